// ==== rtl/ext_bus_small_access_packer.v ====
/*
 * Request splitting and byte-lane packing of the external bus unit, with
 * the write-data FIFO that feeds it.
 * Assumes one clock mclk; pins from outside are synchronised here; the
 * transfer acknowledge pin is high for one mclk cycle per beat.
 */
// Operation
// - Split a request into several transactions when it exceeds port or burst length.
// - Whole split sequence is atomic; bus busy and grant hold stay set throughout.
// - Non-burst: 8B/32-bit two, 8B/16-bit four, 32B/16-bit sixteen single beats.
// - 32 bytes to non-burstable 32-bit destination are eight single 32-bit beats.
// - 4-word burst bank: 32-byte read is two back-to-back 16-byte bursts.
// - 4 bytes non-chip-select on 16-bit port: two accesses, or one 2-beat burst.
// - No dead cycles between split transfers except external-ack writes larger than 64 bits.
// - External-ack split writes hold read_not_write; one gap at 64-bit boundaries.
// - 32-byte single-beat external-ack write gets the gap after accesses 2, 4 and 6 on a 32-bit port, 4, 8 and 12 on a 16-bit port.
// - Second burst address: low 5 bits plus 0x10, no carry, low 4 bits cleared.
// - Internal sizes 1,2,4,8,32; external 1,2,4; others undefined, no error.
// - Natural alignment for halfword and word, 8-byte alignment for 8- and 32-byte requests; bytes any address.
// - Misaligned internal request gets internal error, no external access, no error ack.
// - Misaligned external master access ends with transfer_error_ack, not forwarded.
// - 32-bit port uses lanes 0-31, 16-bit port lanes 0-15, always.
// - Size codes 01 byte, 10 halfword, 00 word; read lanes chosen by address.
// - 32-bit port writes replicate bytes onto upper lanes as tabulated.
// - Word to 16-bit port: two transactions, most significant half first.
// - In 16-bit data bus mode every transfer uses the 16-bit lane mapping.
`timescale 1ns/1ps
`include "ext_bus_defs.vh"

// ****************************************
// Write data FIFO
// ****************************************
module data_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH = 32,
	parameter AW = 5
) (
	input wire mclk,
	input wire resetn,
	input wire inValid,
	output reg inReady,
	input wire [WIDTH-1:0] inData,
	output wire outValid,
	input wire outReady,
	output wire [WIDTH-1:0] outData
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wrPtr;
	reg [AW-1:0] rdPtr;
	reg [AW:0] count;
	wire push = inValid & inReady;
	wire pop = outValid & outReady;
	wire [AW:0] next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

	assign outValid = (count != {(AW+1){1'b0}});
	assign outData = mem[rdPtr];

	always @(posedge mclk) begin
		if (push)
			mem[wrPtr] <= inData;
	end

	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			wrPtr <= {AW{1'b0}};
			rdPtr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
			inReady <= 1'b1;
		end else begin
			if (push)
				wrPtr <= wrPtr + 1'b1;
			if (pop)
				rdPtr <= rdPtr + 1'b1;
			count <= next_count;
			// Ready drops as soon as the last slot fills, so the source stalls
			inReady <= (next_count != DEPTH[AW:0]);
		end
	end
endmodule

// ****************************************
// Sequencer and lane packing
// ****************************************
module ext_bus_small_access_packer #(
	parameter FIFO_DEPTH = 32,
	parameter FIFO_AW = 5
) (
	input wire mclk,
	input wire resetn,
	input wire reqValid,
	output reg reqReady,
	input wire [31:0] reqAddr,
	input wire [2:0] reqSize,
	input wire reqWrite,
	input wire reqChipSelect,
	input wire reqExtAck,
	output reg reqError,
	input wire wrValid,
	output wire wrReady,
	input wire [31:0] wrData,
	output reg rdValid,
	output reg [31:0] rdData,
	input wire burst_inhibit,
	input wire burst_length_sel,
	input wire port_width_sel,
	input wire data_bus_width_mode,
	output reg transfer_start,
	output reg [31:0] xferAddr,
	output reg [1:0] transfer_size_code,
	output reg read_not_write,
	output reg burstXfer,
	input wire transfer_ack,
	input wire [31:0] dataIn,
	output reg [31:0] dataOut,
	output reg [3:0] dataOutEn,
	output reg bus_busy,
	output reg grantHold,
	input wire extReqValid,
	input wire [1:0] extAddrLow,
	input wire [1:0] extSizeCode,
	output reg transfer_error_ack,
	output reg extForward
);
	// ****************************************
	// Pin synchronisers
	// ****************************************
	reg [37:0] syncA;
	reg [37:0] syncB;
	reg extSeen;
	wire [31:0] din = syncB[31:0];
	wire ackS = syncB[32];
	wire [1:0] extSzS = syncB[34:33];
	wire [1:0] extAdS = syncB[36:35];
	wire extValS = syncB[37];
	wire extMis = (extSzS == `TSZ_HALF && extAdS[0]) ||
		(extSzS == `TSZ_WORD && extAdS != 2'h0);

	// ****************************************
	// Request decode
	// ****************************************
	reg [5:0] reqBytes;
	always @* begin
		case (reqSize)
			`REQ_SZ_1: reqBytes = 6'h01;
			`REQ_SZ_2: reqBytes = 6'h02;
			`REQ_SZ_4: reqBytes = 6'h04;
			`REQ_SZ_8: reqBytes = 6'h08;
			default: reqBytes = 6'h20;
		endcase
	end
	wire w16Req = port_width_sel | data_bus_width_mode;
	wire [5:0] portBytes = w16Req ? 6'h02 : 6'h04;
	wire csBurst = reqChipSelect & ~burst_inhibit & (reqBytes == 6'h20);
	wire dbmBurst = ~reqChipSelect & data_bus_width_mode & (reqBytes == 6'h04);
	wire reqMis = (reqBytes == 6'h02 && reqAddr[0]) ||
		(reqBytes == 6'h04 && reqAddr[1:0] != 2'h0) ||
		(reqBytes > 6'h04 && reqAddr[2:0] != 3'h0);
	wire [5:0] singleCount = w16Req ? {1'b0, reqBytes[5:1]} : {2'h0, reqBytes[5:2]};

	// ****************************************
	// Sequencer state
	// ****************************************
	reg [3:0] state;
	reg [31:0] curAddr;
	reg [31:0] dataAddr;
	reg [31:0] wordBuf;
	reg [15:0] rdHi;
	reg [5:0] bytes;
	reg [5:0] xferLeft;
	reg [4:0] beatsPer;
	reg [4:0] beatLeft;
	reg [1:0] xsize;
	reg w16;
	reg isWrite;
	reg extAck;
	reg isBurst;
	reg first;

	wire [31:0] unit = w16 ? 32'h2 : 32'h4;
	wire [31:0] nextData = dataAddr + unit;
	wire needWord = first | ~w16 | ~dataAddr[1];
	wire fifoValid;
	wire [31:0] fifoData;
	wire startGo = (state == `ST_START) && !(isWrite && needWord && !fifoValid);
	wire fifoPop = startGo & isWrite & needWord;
	wire [31:0] useWord = fifoPop ? fifoData : wordBuf;
	wire [4:0] lowSum = curAddr[4:0] + `BURST2_ADD;
	wire [31:0] burst2Addr = {curAddr[31:5], lowSum[4], 4'h0};
	wire [15:0] din16 = din[31:16];
	wire lastBeat = (beatLeft == 5'h01);
	wire lastXfer = (xferLeft == 6'h01);
	wire gapNeeded = isWrite & extAck & (bytes > `GAP_BYTES) & (nextData[2:0] == 3'h0);

	// Lane steering for writes: {enables, lanes}, lane 0 is bits 31:24
	function [35:0] steer;
		input [31:0] w;
		input [1:0] k;
		input w16f;
		input [1:0] code;
		reg [7:0] b;
		reg [15:0] h;
		begin
			case (k)
				2'h0: b = w[31:24];
				2'h1: b = w[23:16];
				2'h2: b = w[15:8];
				default: b = w[7:0];
			endcase
			h = k[1] ? w[15:0] : w[31:16];
			if (w16f) begin
				if (code == `TSZ_BYTE)
					steer = {(k[0] ? 4'h4 : 4'h8), b, b, 16'h0};
				else
					steer = {4'hc, h, 16'h0};
			end else if (code == `TSZ_BYTE) begin
				steer = {1'b1, k[0], k == 2'h2, k == 2'h3, b, b, b, b};
			end else if (code == `TSZ_HALF) begin
				steer = k[1] ? {4'hf, h, h} : {4'hc, h, 16'h0};
			end else begin
				steer = {4'hf, w};
			end
		end
	endfunction

	wire [35:0] lanesNow = steer(useWord, dataAddr[1:0], w16, xsize);
	wire [35:0] lanesNext = steer(wordBuf, nextData[1:0], w16, xsize);

	data_fifo #(
		.WIDTH(32),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) wrFifo (
		.mclk(mclk),
		.resetn(resetn),
		.inValid(wrValid),
		.inReady(wrReady),
		.inData(wrData),
		.outValid(fifoValid),
		.outReady(fifoPop),
		.outData(fifoData)
	);

	// ****************************************
	// Synchronisers and external master check
	// ****************************************
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			syncA <= 38'h0;
			syncB <= 38'h0;
			extSeen <= 1'b0;
			transfer_error_ack <= 1'b0;
			extForward <= 1'b0;
		end else begin
			syncA <= {extReqValid, extAddrLow, extSizeCode, transfer_ack, dataIn};
			syncB <= syncA;
			extSeen <= extValS;
			// Misaligned external access is ended here and never reaches the inside
			transfer_error_ack <= extValS & ~extSeen & extMis;
			extForward <= extValS & ~extSeen & ~extMis;
		end
	end

	// ****************************************
	// Main sequencer
	// ****************************************
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state <= `ST_IDLE;
			reqReady <= 1'b0;
			reqError <= 1'b0;
			rdValid <= 1'b0;
			rdData <= `RST_WORD;
			transfer_start <= 1'b0;
			xferAddr <= `RST_WORD;
			transfer_size_code <= `TSZ_WORD;
			read_not_write <= `RST_RNW;
			burstXfer <= 1'b0;
			dataOut <= `RST_WORD;
			dataOutEn <= 4'h0;
			bus_busy <= 1'b0;
			grantHold <= 1'b0;
			curAddr <= `RST_WORD;
			dataAddr <= `RST_WORD;
			wordBuf <= `RST_WORD;
			rdHi <= 16'h0;
			bytes <= 6'h0;
			xferLeft <= 6'h0;
			beatsPer <= 5'h0;
			beatLeft <= 5'h0;
			xsize <= `TSZ_WORD;
			w16 <= 1'b0;
			isWrite <= 1'b0;
			extAck <= 1'b0;
			isBurst <= 1'b0;
			first <= 1'b0;
		end else begin
			reqError <= 1'b0;
			rdValid <= 1'b0;
			transfer_start <= 1'b0;
			case (state)
				`ST_IDLE: begin
					reqReady <= 1'b1;
					if (reqValid && reqReady) begin
						reqReady <= 1'b0;
						if (reqMis) begin
							// Error stays internal: no start, no error ack
							reqError <= 1'b1;
						end else begin
							curAddr <= reqAddr;
							dataAddr <= reqAddr;
							bytes <= reqBytes;
							w16 <= w16Req;
							isWrite <= reqWrite;
							extAck <= reqExtAck;
							first <= 1'b1;
							if (csBurst) begin
								isBurst <= 1'b1;
								xferLeft <= burst_length_sel ? 6'h02 : 6'h01;
								beatsPer <= (burst_length_sel ? `BURST_WORDS_4 : `BURST_WORDS_8)
									<< w16Req;
								xsize <= w16Req ? `TSZ_HALF : `TSZ_WORD;
							end else if (dbmBurst) begin
								isBurst <= 1'b1;
								xferLeft <= 6'h01;
								beatsPer <= `DBM_BURST_BEATS;
								xsize <= `TSZ_HALF;
							end else begin
								isBurst <= 1'b0;
								// Single transaction when it fits the port
								xferLeft <= (reqBytes > portBytes) ? singleCount : 6'h01;
								beatsPer <= 5'h01;
								if (reqBytes >= portBytes)
									xsize <= w16Req ? `TSZ_HALF : `TSZ_WORD;
								else if (reqBytes == 6'h02)
									xsize <= `TSZ_HALF;
								else
									xsize <= `TSZ_BYTE;
							end
							bus_busy <= 1'b1;
							grantHold <= 1'b1;
							state <= `ST_START;
						end
					end
				end
				`ST_START: begin
					read_not_write <= ~isWrite;
					if (startGo) begin
						transfer_start <= 1'b1;
						xferAddr <= curAddr;
						transfer_size_code <= xsize;
						burstXfer <= isBurst;
						beatLeft <= beatsPer;
						first <= 1'b0;
						if (isWrite) begin
							wordBuf <= useWord;
							dataOutEn <= lanesNow[35:32];
							dataOut <= lanesNow[31:0];
						end
						state <= `ST_BEAT;
					end
				end
				`ST_BEAT: begin
					if (ackS) begin
						beatLeft <= beatLeft - 5'h01;
						dataAddr <= nextData;
						if (!isWrite) begin
							// Read lanes follow the address of the beat
							if (!w16) begin
								rdValid <= 1'b1;
								rdData <= din;
							end else if (bytes <= 6'h02) begin
								rdValid <= 1'b1;
								rdData <= dataAddr[1] ? {16'h0, din16} : {din16, 16'h0};
							end else if (!dataAddr[1]) begin
								rdHi <= din16;
							end else begin
								rdValid <= 1'b1;
								rdData <= {rdHi, din16};
							end
						end
						if (lastBeat) begin
							xferLeft <= xferLeft - 6'h01;
							curAddr <= isBurst ? burst2Addr : curAddr + unit;
							if (lastXfer) begin
								dataOutEn <= 4'h0;
								read_not_write <= `RST_RNW;
								bus_busy <= 1'b0;
								grantHold <= 1'b0;
								state <= `ST_IDLE;
							end else if (gapNeeded) begin
								// Gap before the next 64 bits; their write data is popped at each following start that needs a new word
								state <= `ST_GAP;
							end else begin
								// Straight to the next start, no added dead cycle
								state <= `ST_START;
							end
						end else if (isWrite) begin
							dataOutEn <= lanesNext[35:32];
							dataOut <= lanesNext[31:0];
						end
					end
				end
				`ST_GAP: begin
					// Read_not_write is up for this one extra cycle only
					read_not_write <= 1'b1;
					state <= `ST_START;
				end
				default: begin
					state <= `ST_IDLE;
				end
			endcase
		end
	end
endmodule

// ==== pkg/ext_bus_defs.vh ====
/*
 * Constants of the external bus small-access packer: request size codes,
 * external transfer size codes, state codes and reset values.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef EXT_BUS_DEFS_VH
`define EXT_BUS_DEFS_VH

// ****************************************
// Request size codes (internal master)
// ****************************************
`define REQ_SZ_1 3'h0
`define REQ_SZ_2 3'h1
`define REQ_SZ_4 3'h2
`define REQ_SZ_8 3'h3
`define REQ_SZ_32 3'h4

// ****************************************
// External transfer size codes
// ****************************************
`define TSZ_BYTE 2'h1
`define TSZ_HALF 2'h2
`define TSZ_WORD 2'h0

// ****************************************
// Burst geometry
// ****************************************
`define BURST_WORDS_8 5'h08
`define BURST_WORDS_4 5'h04
`define BURST2_ADD 5'h10
`define DBM_BURST_BEATS 5'h02
`define GAP_BYTES 6'h08

// ****************************************
// Sequencer states, one-hot
// ****************************************
`define ST_IDLE 4'h1
`define ST_START 4'h2
`define ST_BEAT 4'h4
`define ST_GAP 4'h8

// ****************************************
// Reset values
// ****************************************
`define RST_WORD 32'h0
`define RST_RNW 1'h1

`endif

// ==== testbench/ext_bus_chk.sv ====
/* Checker of the small-access packer ports.
   Assumes config ports stay still while a sequence runs. */
`timescale 1ns/1ps
module ext_bus_chk (
	input wire mclk,
	input wire resetn,
	input wire reqReady,
	input wire reqError,
	input wire transfer_start,
	input wire [31:0] xferAddr,
	input wire [1:0] transfer_size_code,
	input wire read_not_write,
	input wire burstXfer,
	input wire [3:0] dataOutEn,
	input wire bus_busy,
	input wire grantHold,
	input wire port_width_sel,
	input wire data_bus_width_mode,
	input wire extReqValid,
	input wire [1:0] extAddrLow,
	input wire [1:0] extSizeCode,
	input wire transfer_error_ack,
	input wire extForward
);
	// ****
	// Properties
	// ****
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!resetn);
	wire extMis = (extSizeCode == 2'h0 && extAddrLow != 2'h0) || (extSizeCode == 2'h2 && extAddrLow[0]);
	property p_start; transfer_start |-> bus_busy && grantHold && !reqReady; endproperty
	a_start: assert property (p_start) else $error("start outside busy");
	property p_err; reqError |-> !transfer_start [*4]; endproperty
	a_err: assert property (p_err) else $error("start after error");
	property p_err_tea; reqError |-> !transfer_error_ack && !bus_busy; endproperty
	a_err_tea: assert property (p_err_tea) else $error("error ack on internal error");
	property p_ext_mis; $rose(extReqValid) && extMis |-> ##[1:5] transfer_error_ack; endproperty
	a_ext_mis: assert property (p_ext_mis) else $error("no error ack");
	property p_tea_fwd; transfer_error_ack |-> !extForward; endproperty
	a_tea_fwd: assert property (p_tea_fwd) else $error("misaligned forwarded");
	property p_word; transfer_start && transfer_size_code == 2'h0 |-> xferAddr[1:0] == 2'h0; endproperty
	a_word: assert property (p_word) else $error("word misaligned");
	property p_half; transfer_start && transfer_size_code == 2'h2 |-> !xferAddr[0]; endproperty
	a_half: assert property (p_half) else $error("half misaligned");
	property p_lane; bus_busy && (port_width_sel || data_bus_width_mode) |-> dataOutEn[1:0] == 2'h0;
	endproperty
	a_lane: assert property (p_lane) else $error("low lanes driven");
	property p_gap; $rose(read_not_write) && bus_busy |=> !read_not_write || !bus_busy; endproperty
	a_gap: assert property (p_gap) else $error("gap too long");
	c_err: cover property (reqError);
	c_tea: cover property (transfer_error_ack);
	c_burst: cover property (transfer_start && burstXfer);
endmodule
bind ext_bus_small_access_packer ext_bus_chk ext_bus_chk_inst (
	.mclk(mclk), .resetn(resetn), .reqReady(reqReady), .reqError(reqError),
	.transfer_start(transfer_start), .xferAddr(xferAddr), .burstXfer(burstXfer),
	.transfer_size_code(transfer_size_code), .read_not_write(read_not_write),
	.dataOutEn(dataOutEn), .bus_busy(bus_busy), .grantHold(grantHold),
	.port_width_sel(port_width_sel), .data_bus_width_mode(data_bus_width_mode),
	.extReqValid(extReqValid), .extAddrLow(extAddrLow), .extSizeCode(extSizeCode),
	.transfer_error_ack(transfer_error_ack), .extForward(extForward)
);

// ==== testbench/ext_mem_model.sv ====
/* Far-side memory: acks each start, one pulse per beat, with read data.
   Assumes active-high ack; burst beats given by the bench. */
`timescale 1ns/1ps
module ext_mem_model (
	input wire mclk,
	input wire resetn,
	input wire transfer_start,
	input wire burstXfer,
	input wire [31:0] xferAddr,
	input wire [3:0] beats,
	input wire [3:0] waitCyc,
	output reg transfer_ack,
	output reg [31:0] dataIn
);
	integer i;
	initial begin
		transfer_ack = 1'b0;
		dataIn = 32'h0;
		forever begin
			@(posedge mclk);
			if (resetn && transfer_start) begin
				for (i = 0; i < (burstXfer ? beats : 1); i = i + 1) begin
					repeat (waitCyc + 1) @(posedge mclk);
					transfer_ack <= 1'b1;
					dataIn <= {xferAddr[15:0], 16'h5a00};
					@(posedge mclk);
					transfer_ack <= 1'b0;
					// Released lanes must not keep the old value
					dataIn <= ~dataIn;
				end
			end
		end
	end
endmodule

// ==== testbench/testbench.sv ====
/* Self-checking bench of the small-access packer.
   Assumes the partner model answers every start. */
`timescale 1ns/1ps
`include "ext_bus_defs.vh"
module testbench;
	reg mclk = 1'b0, resetn = 1'b0, reqValid = 1'b0, reqWrite = 1'b0, reqChipSelect = 1'b0;
	reg reqExtAck = 1'b0, wrValid = 1'b0, extReqValid = 1'b0, burst_inhibit = 1'b1;
	reg burst_length_sel = 1'b0, port_width_sel = 1'b0, data_bus_width_mode = 1'b0;
	reg [31:0] reqAddr = 32'h0, wrData = 32'h0, addr2 = 32'h0, rdLast = 32'h0, outLast = 32'h0;
	reg [2:0] reqSize = 3'h0;
	reg [1:0] extAddrLow = 2'h0, extSizeCode = 2'h0, szLast = 2'h0;
	reg [3:0] beats = 4'h1, waitCyc = 4'h0, enLast = 4'h0;
	reg prevRnw = 1'b1, sawErr = 1'b0, sawTea = 1'b0, sawFwd = 1'b0, sawBurst = 1'b0;
	wire reqReady, reqError, wrReady, rdValid, transfer_start, read_not_write, burstXfer;
	wire transfer_ack, bus_busy, grantHold, transfer_error_ack, extForward;
	wire [31:0] rdData, xferAddr, dataIn, dataOut;
	wire [1:0] transfer_size_code;
	wire [3:0] dataOutEn;
	integer miscompares = 0, comparisons = 0, nStart = 0, nGap = 0, k, n;
	reg [7:0] b;
	ext_bus_small_access_packer ext_bus_small_access_packer_inst (
		.mclk(mclk), .resetn(resetn), .reqValid(reqValid), .reqReady(reqReady),
		.reqAddr(reqAddr), .reqSize(reqSize), .reqWrite(reqWrite), .reqChipSelect(reqChipSelect),
		.reqExtAck(reqExtAck), .reqError(reqError), .wrValid(wrValid), .wrReady(wrReady),
		.wrData(wrData), .rdValid(rdValid), .rdData(rdData), .burst_inhibit(burst_inhibit),
		.burst_length_sel(burst_length_sel), .port_width_sel(port_width_sel),
		.data_bus_width_mode(data_bus_width_mode), .transfer_start(transfer_start),
		.xferAddr(xferAddr), .transfer_size_code(transfer_size_code),
		.read_not_write(read_not_write), .burstXfer(burstXfer), .transfer_ack(transfer_ack),
		.dataIn(dataIn), .dataOut(dataOut), .dataOutEn(dataOutEn), .bus_busy(bus_busy),
		.grantHold(grantHold), .extReqValid(extReqValid), .extAddrLow(extAddrLow),
		.extSizeCode(extSizeCode), .transfer_error_ack(transfer_error_ack),
		.extForward(extForward));
	ext_mem_model ext_mem_model_inst (.mclk(mclk), .resetn(resetn),
		.transfer_start(transfer_start), .burstXfer(burstXfer), .xferAddr(xferAddr),
		.beats(beats), .waitCyc(waitCyc), .transfer_ack(transfer_ack), .dataIn(dataIn));
	always #2.5 mclk = ~mclk;
	// ****
	// Observation
	// ****
	always @(posedge mclk) begin
		prevRnw <= read_not_write;
		if (rdValid) rdLast <= rdData;
		if (reqError) sawErr <= 1'b1;
		if (transfer_error_ack) sawTea <= 1'b1;
		if (extForward) sawFwd <= 1'b1;
		if (transfer_start) begin
			nStart <= nStart + 1;
			if (nStart == 1) addr2 <= xferAddr;
			if (nStart > 0 && prevRnw) nGap <= nGap + 1;
			if (burstXfer) sawBurst <= 1'b1;
			szLast <= transfer_size_code;
			outLast <= dataOut;
			enLast <= dataOutEn;
		end
	end
	// ****
	// Tasks
	// ****
	task check(input [31:0] seen, input [31:0] exp, input [8*6:1] what);
		begin
			comparisons = comparisons + 1;
			if (seen !== exp) begin
				miscompares = miscompares + 1;
				$display("FAIL %0s expected %h seen %h", what, exp, seen);
			end
		end
	endtask
	task req(input [31:0] a, input [2:0] sz, input w, input cs, input ea, input [3:0] cfg);
		integer t;
		begin
			t = 0;
			while (reqReady !== 1'b1 && t < 20) begin
				@(negedge mclk);
				t = t + 1;
			end
			check(reqReady, 1, "ready");
			{burst_inhibit, burst_length_sel, port_width_sel, data_bus_width_mode} = cfg;
			{reqAddr, reqSize, reqWrite, reqChipSelect, reqExtAck} = {a, sz, w, cs, ea};
			nStart = 0;
			nGap = 0;
			{sawErr, sawBurst} = 2'h0;
			reqValid = 1'b1;
			@(negedge mclk);
			reqValid = 1'b0;
			repeat (4) @(negedge mclk);
			while (bus_busy !== 1'b0 && t < 3000) begin
				@(negedge mclk);
				t = t + 1;
			end
			check(bus_busy, 0, "idle");
			repeat (2) @(negedge mclk);
		end
	endtask
	task t_split;
		for (k = 0; k < 6; k = k + 1) begin
			waitCyc = k;
			n = (k < 2) ? 4 : (k < 4) ? 8 : 32;
			req(32'h200, (k < 2) ? `REQ_SZ_4 : (k < 4) ? `REQ_SZ_8 : `REQ_SZ_32, 1'b0, 1'b1, 1'b0,
				{2'h2, k[0], 1'b0});
			check(nStart, n >> (k[0] ? 1 : 2), "starts");
			if (k == 1) begin
				check(rdLast, 32'h02000202, "rdata");
				check(addr2, 32'h202, "addr2");
				check(szLast, `TSZ_HALF, "size");
			end
		end
	endtask
	task t_burst;
		for (k = 0; k < 3; k = k + 1) begin
			beats = k ? 4'h8 : 4'h4;
			reqAddr = k ? 32'h128 : 32'h118;
			req(reqAddr, `REQ_SZ_32, 1'b0, 1'b1, 1'b0, {1'b0, k < 2, k[0], 1'b0});
			check(nStart, (k < 2) ? 2 : 1, "starts");
			if (k < 2)
				check(addr2, {reqAddr[31:5], ~reqAddr[4], 4'h0}, "addr2");
			check(sawBurst, 1, "burst");
		end
	endtask
	task t_dbm;
		for (k = 0; k < 2; k = k + 1) begin
			beats = 4'h2;
			req(32'h300, `REQ_SZ_4, 1'b0, 1'b0, 1'b0, {3'h5, k[0]});
			check(nStart, 2 - k, "starts");
			check(sawBurst, k, "burst");
		end
	endtask
	task t_mis;
		for (k = 0; k < 3; k = k + 1) begin
			req(32'h101 + k[1], (k == 0) ? `REQ_SZ_2 : (k == 1) ? `REQ_SZ_4 : `REQ_SZ_8,
				1'b0, 1'b1, 1'b0, 4'h8);
			check({sawErr, sawTea, nStart[3:0]}, 6'h20, "miserr");
		end
	endtask
	task t_ext;
		for (k = 0; k < 2; k = k + 1) begin
			{sawTea, sawFwd} = 2'h0;
			{extSizeCode, extAddrLow, extReqValid} = {`TSZ_WORD, k ? 2'h0 : 2'h2, 1'b1};
			repeat (6) @(negedge mclk);
			extReqValid = 1'b0;
			repeat (2) @(negedge mclk);
			check({sawTea, sawFwd}, k ? 2'h1 : 2'h2, "extack");
		end
	endtask
	task t_write;
		begin
			n = 0;
			wrValid = 1'b1;
			while (wrReady === 1'b1 && n < 40) begin
				wrData = 32'h1000 + n;
				@(negedge mclk);
				n = n + 1;
			end
			wrValid = 1'b0;
			check(n, 32, "fifo");
			// Four gapped writes drain exactly the full buffer
			for (k = 0; k < 4; k = k + 1) begin
				waitCyc = k;
				req(32'h400, `REQ_SZ_32, 1'b1, 1'b0, 1'b1, 4'h8);
				check(nStart, 8, "starts");
				check(nGap, 3, "gaps");
			end
			check(wrReady, 1, "fifo");
		end
	endtask
	task t_lanes;
		for (k = 0; k < 4; k = k + 1) begin
			wrValid = 1'b1;
			wrData = 32'h11223344;
			@(negedge mclk);
			wrValid = 1'b0;
			req(32'h600 + k, `REQ_SZ_1, 1'b1, 1'b1, 1'b0, 4'h8);
			b = wrData >> (8 * (3 - k));
			check(enLast, {1'b1, k[0], k == 2, k == 3}, "lanes");
			check(outLast & {{8{enLast[3]}}, {8{enLast[2]}}, {8{enLast[1]}}, {8{enLast[0]}}},
				{b, k[0] ? b : 8'h0, (k == 2) ? b : 8'h0, (k == 3) ? b : 8'h0}, "data");
			check(szLast, `TSZ_BYTE, "size");
		end
	endtask
	task finish_test;
		begin
			if (miscompares == 0 && comparisons > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	initial begin
		repeat (2) @(negedge mclk);
		resetn = 1'b1;
		repeat (2) @(negedge mclk);
		t_split;
		t_burst;
		t_dbm;
		t_mis;
		t_ext;
		t_write;
		t_lanes;
		finish_test;
	end
	initial begin
		#100000;
		miscompares = miscompares + 1;
		finish_test;
	end
endmodule
